// ==== vector_type_config_register.sv ====
`timescale 1ns/1ns
`include "vtype_defs.svh"

// Functional notes
// - Read-only; changes only on configuration instructions.
// - Fixed field positions: illegal, policies, width, multiplier.
// - Middle reserved bits must be zero.
// - Width codes 000-011 mean 8,16,32,64 bits.
// - Width codes with top bit set are reserved.
// - Register holds register-bits over width elements.
// - Multipliers 1, 2, 4, 8 are accepted.
// - Widest 32: also one half, one quarter.
// - Widest 64: half, quarter, eighth supported.
// - Multipliers down to narrowest over widest supported.
// - Fractional multiplier: widths up to multiplier times widest.
// - Multiplier below ratio is reserved, flagged illegal.
// - Unsupported combinations raise the illegal flag.
// - Widest 32 may store seven bits only.
// - Widening operands use double the multiplier.
// - Configuration may fuse with following instruction.
// - Multiplier code is signed exponent, 100 reserved.
// - Max elements is multiplier times register-bits over width.
// - Agnostic may keep or fill ones.

module vector_type_config_register
    import vtype_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic cfg_valid, // Configuration instruction retires this cycle
    input wire logic [31:0] cfg_vtype, // Type word requested by that instruction
    input wire logic csr_rd_en, // Register read strobe
    input wire logic csr_wr_en, // Register write attempt strobe
    input wire logic [11:0] csr_addr, // Register address
    output logic [31:0] csr_rd_data, // Read data
    output logic csr_rd_valid, // Read data valid pulse
    output logic csr_wr_denied, // Write attempt refused pulse
    output logic [31:0] vtype_value, // Current type word
    output logic illegal, // Illegal-configuration flag
    output logic tail_agnostic, // Tail policy
    output logic mask_agnostic, // Inactive-element policy
    output logic [7:0] sew_bits, // Selected element width in bits
    output logic [2:0] register_group_multiplier_code, // Group multiplier code
    output logic [16:0] elems_per_reg, // Elements per single register
    output logic [16:0] max_element_count, // Elements per instruction
    output logic [2:0] wide_register_group_multiplier_code, // Multiplier for double-width operands
    output logic wide_legal, // Double-width operands are supported
    output logic cfg_done // Update applied pulse
);
    logic req_legal;
    logic hit;
    logic vill_cur;
    logic vma_cur;
    logic vta_cur;
    logic [2:0] sew_cur;
    logic [2:0] register_group_multiplier_cur;
    logic vill_nxt;
    logic vma_nxt;
    logic vta_nxt;
    logic [2:0] sew_nxt;
    logic [2:0] register_group_multiplier_nxt;
    log2_t register_group_multiplier_exp_nxt;
    log2_t sew_log_nxt;
    log2_t cnt_log_nxt;
    log2_t per_log_nxt;

    vtype_legality u_legal (
        .req_vtype(cfg_vtype),
        .legal(req_legal)
    );

    assign hit = (csr_addr == `VT_CSR_ADDR);

    // An unsupported request leaves only the illegal flag set.
    always_comb begin
        if (cfg_valid) begin
            vill_nxt = !req_legal;
            vma_nxt = req_legal & cfg_vtype[`VT_VMA_BIT];
            vta_nxt = req_legal & cfg_vtype[`VT_VTA_BIT];
            sew_nxt = req_legal ? cfg_vtype[`VT_SEW_HI:`VT_SEW_LO] : '0;
            register_group_multiplier_nxt = req_legal ? cfg_vtype[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] : '0;
        end else begin
            vill_nxt = vill_cur;
            vma_nxt = vma_cur;
            vta_nxt = vta_cur;
            sew_nxt = sew_cur;
            register_group_multiplier_nxt = register_group_multiplier_cur;
        end
        register_group_multiplier_exp_nxt = log2_t'($signed(register_group_multiplier_nxt));
        sew_log_nxt = log2_t'(sew_nxt[1:0]) + log2_t'(`VT_NARROWEST_ELEMENT_BITS_LOG);
        per_log_nxt = log2_t'(`VT_VECTOR_REGISTER_BITS_LOG) - sew_log_nxt;
        cnt_log_nxt = per_log_nxt + register_group_multiplier_exp_nxt;
    end

    generate
        if (`VT_WIDEST_ELEMENT_BITS == 32) begin : g_compact
            // Seven bits of state; the unused 64-bit width code marks illegal.
            logic [6:0] st_r;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    st_r <= `VT_STATE7_RESET;
                end else begin
                    st_r <= {vma_nxt, vta_nxt, vill_nxt ? 2'b11 : sew_nxt[1:0], register_group_multiplier_nxt};
                end
            end
            assign vill_cur = (st_r[4:3] == 2'b11);
            assign vma_cur = st_r[6];
            assign vta_cur = st_r[5];
            assign sew_cur = vill_cur ? 3'h0 : {1'b0, st_r[4:3]};
            assign register_group_multiplier_cur = st_r[2:0];
        end else begin : g_full
            logic [8:0] st_r;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    st_r <= `VT_STATE_RESET;
                end else begin
                    st_r <= {vill_nxt, vma_nxt, vta_nxt, sew_nxt, register_group_multiplier_nxt};
                end
            end
            assign vill_cur = st_r[8];
            assign vma_cur = st_r[7];
            assign vta_cur = st_r[6];
            assign sew_cur = st_r[5:3];
            assign register_group_multiplier_cur = st_r[2:0];
        end
    endgenerate

    // Visible type word and decoded fields.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vtype_value <= `VT_RESET_VAL;
            illegal <= 1'b1;
            tail_agnostic <= 1'b0;
            mask_agnostic <= 1'b0;
            sew_bits <= '0;
            register_group_multiplier_code <= '0;
        end else begin
            vtype_value <= '0;
            vtype_value[`VT_VILL_BIT] <= vill_nxt;
            vtype_value[`VT_VMA_BIT] <= vma_nxt;
            vtype_value[`VT_VTA_BIT] <= vta_nxt;
            vtype_value[`VT_SEW_HI:`VT_SEW_LO] <= sew_nxt;
            vtype_value[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] <= register_group_multiplier_nxt;
            illegal <= vill_nxt;
            // The datapath treats agnostic sets as undisturbed, which is always allowed.
            tail_agnostic <= vta_nxt;
            mask_agnostic <= vma_nxt;
            sew_bits <= vill_nxt ? 8'h00 : (`VT_EIGHT << sew_nxt[1:0]);
            register_group_multiplier_code <= register_group_multiplier_nxt;
        end
    end

    // Element counts follow from the new fields in the same edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elems_per_reg <= '0;
            max_element_count <= '0;
        end else begin
            elems_per_reg <= vill_nxt ? '0 : (`VT_ONE_CNT << per_log_nxt[3:0]);
            max_element_count <= (vill_nxt || cnt_log_nxt < 0) ? '0 : (`VT_ONE_CNT << cnt_log_nxt[3:0]);
        end
    end

    // Double-width operands need twice the multiplier and fit under the widest width.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wide_register_group_multiplier_code <= '0;
            wide_legal <= 1'b0;
        end else begin
            wide_register_group_multiplier_code <= register_group_multiplier_nxt + 3'h1;
            wide_legal <= !vill_nxt && (register_group_multiplier_nxt != REGISTER_GROUP_MULTIPLIER_8)
                && (sew_log_nxt + log2_t'(1) <= log2_t'(`VT_WIDEST_ELEMENT_BITS_LOG));
        end
    end

    // Register port: readable, writes refused; a configuration may retire in the
    // same cycle as the following instruction, which sees the new value next cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            csr_rd_data <= '0;
            csr_rd_valid <= 1'b0;
            csr_wr_denied <= 1'b0;
            cfg_done <= 1'b0;
        end else begin
            csr_rd_valid <= csr_rd_en && hit;
            csr_rd_data <= (csr_rd_en && hit) ? vtype_value : '0;
            csr_wr_denied <= csr_wr_en && hit;
            cfg_done <= cfg_valid;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_wr_only;
        csr_wr_en && hit && !cfg_valid;
    endsequence

    sequence s_int_cfg;
        cfg_valid && !cfg_vtype[`VT_REGISTER_GROUP_MULTIPLIER_HI] && !cfg_vtype[`VT_SEW_HI]
            && (cfg_vtype[`VT_RSV_HI:`VT_RSV_LO] == '0);
    endsequence

    AST_WRITE_IGNORED: assert property (s_wr_only |=> csr_wr_denied && $stable(vtype_value))
        else $error("write changed the type register");
    AST_RSV_ZERO: assert property (vtype_value[`VT_RSV_HI:`VT_RSV_LO] == '0)
        else $error("reserved bits read non-zero");
    AST_LAYOUT: assert property (cfg_valid && req_legal
        |=> vtype_value[`VT_VMA_BIT:`VT_REGISTER_GROUP_MULTIPLIER_LO] == $past(cfg_vtype[`VT_VMA_BIT:`VT_REGISTER_GROUP_MULTIPLIER_LO]))
        else $error("field layout mismatch");
    AST_RSV_REQ: assert property (cfg_valid && cfg_vtype[`VT_RSV_HI:`VT_RSV_LO] != '0 |=> illegal)
        else $error("reserved request accepted");
    AST_SEW_RSV: assert property (cfg_valid && cfg_vtype[`VT_SEW_HI] |=> illegal && sew_bits == 8'h00)
        else $error("reserved width accepted");
    AST_SEW_DEC: assert property (!illegal |-> sew_bits == (`VT_EIGHT << vtype_value[`VT_SEW_LO+1:`VT_SEW_LO]))
        else $error("width decode wrong");
    AST_REGISTER_GROUP_MULTIPLIER_RSV: assert property (cfg_valid && cfg_vtype[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] == `VT_REGISTER_GROUP_MULTIPLIER_RSV |=> illegal)
        else $error("reserved multiplier accepted");
    AST_INT_REGISTER_GROUP_MULTIPLIER: assert property (s_int_cfg |=> !illegal ##0 (max_element_count == elems_per_reg << register_group_multiplier_code))
        else $error("integer multiplier count wrong");
    AST_FRAC_8: assert property (cfg_valid && cfg_vtype[`VT_RSV_HI:`VT_RSV_LO] == '0
        && cfg_vtype[`VT_SEW_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] == {SEW_8, REGISTER_GROUP_MULTIPLIER_1_8} |=> !illegal)
        else $error("eighth multiplier refused");
    AST_FRAC_CAP: assert property (cfg_valid && cfg_vtype[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] == REGISTER_GROUP_MULTIPLIER_1_2
        && cfg_vtype[`VT_SEW_HI:`VT_SEW_LO] == SEW_64 |=> illegal)
        else $error("width above multiplier cap accepted");
    AST_READ: assert property (csr_rd_en && hit |=> csr_rd_valid && csr_rd_data == $past(vtype_value))
        else $error("read data wrong");

    // Decoded outputs track the stored type word at every edge.
    sequence s_frac_state;
        !illegal && vtype_value[`VT_REGISTER_GROUP_MULTIPLIER_HI];
    endsequence

    sequence s_quiet;
        !cfg_valid;
    endsequence

    sequence s_cfg_then_quiet;
        cfg_valid ##1 !cfg_valid;
    endsequence

    sequence s_rd_miss;
        csr_rd_en && !hit;
    endsequence

    sequence s_wr_miss;
        csr_wr_en && !hit;
    endsequence

    AST_VILL_MIRROR: assert property (illegal == vtype_value[`VT_VILL_BIT])
        else $error("illegal flag differs from the type word");
    AST_STATE_WORD: assert property (vtype_value[`VT_VILL_BIT] == vill_cur
        && vtype_value[`VT_SEW_HI:`VT_SEW_LO] == sew_cur && vtype_value[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] == register_group_multiplier_cur)
        else $error("visible type word differs from stored state");
    AST_VILL_CLEARS: assert property (illegal |-> vtype_value[`VT_RSV_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] == '0)
        else $error("illegal type word keeps a field");
    AST_VILL_ZERO: assert property (illegal
        |-> sew_bits == 8'h00 && elems_per_reg == '0 && max_element_count == '0 && !wide_legal)
        else $error("illegal type word reports a size");
    AST_POLICY: assert property (tail_agnostic == vtype_value[`VT_VTA_BIT]
        && mask_agnostic == vtype_value[`VT_VMA_BIT])
        else $error("policy outputs differ from the type word");
    AST_REGISTER_GROUP_MULTIPLIER_MIRROR: assert property (register_group_multiplier_code == vtype_value[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO])
        else $error("multiplier output differs from the type word");
    AST_SEW_RANGE: assert property (!illegal |-> !vtype_value[`VT_SEW_HI])
        else $error("reserved width code stored");
    AST_REGISTER_GROUP_MULTIPLIER_STATE: assert property (!illegal |-> vtype_value[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] != `VT_REGISTER_GROUP_MULTIPLIER_RSV)
        else $error("reserved multiplier code stored");
    AST_ELEMS: assert property (!illegal
        |-> (elems_per_reg << vtype_value[`VT_SEW_LO+1:`VT_SEW_LO]) == `VT_ELEMS_AT_8)
        else $error("elements per register wrong");
    AST_INT_MAX: assert property (!illegal && !vtype_value[`VT_REGISTER_GROUP_MULTIPLIER_HI]
        |-> max_element_count == (elems_per_reg << register_group_multiplier_code))
        else $error("integer element count wrong");
    AST_FRAC_MAX: assert property (s_frac_state
        |-> max_element_count == (elems_per_reg >> (3'h0 - register_group_multiplier_code)))
        else $error("fractional element count wrong");
    AST_FRAC_SEW: assert property (s_frac_state
        |-> (16'(sew_bits) << (3'h0 - register_group_multiplier_code)) <= `VT_WIDEST_BITS)
        else $error("fractional multiplier holds too wide an element");
    AST_CNT_LIMIT: assert property (max_element_count <= `VT_MAX_CNT)
        else $error("element count above the largest group");
    AST_WIDE: assert property (wide_legal
        |-> !illegal && register_group_multiplier_code != REGISTER_GROUP_MULTIPLIER_8 && 16'(sew_bits) < `VT_WIDEST_BITS)
        else $error("double-width operands claimed where they cannot fit");
    AST_WIDE_CODE: assert property (!illegal |-> wide_register_group_multiplier_code == register_group_multiplier_code + 3'h1)
        else $error("double-width multiplier wrong");
    AST_HOLD: assert property (s_quiet |=> $stable(vtype_value))
        else $error("type word changed without a configuration");
    AST_CFG_DONE: assert property (cfg_valid |=> cfg_done)
        else $error("configuration not reported done");
    AST_DONE_PULSE: assert property (s_quiet |=> !cfg_done)
        else $error("done pulse without a configuration");
    AST_DONE_ONCE: assert property (s_cfg_then_quiet |=> !cfg_done && $stable(vtype_value))
        else $error("done pulse stretched past its instruction");
    AST_READ_MISS: assert property (s_rd_miss |=> !csr_rd_valid && csr_rd_data == '0)
        else $error("read of another register answered");
    AST_READ_IDLE: assert property (!csr_rd_en |=> !csr_rd_valid && csr_rd_data == '0)
        else $error("read answer without a read");
    AST_WRITE_MISS: assert property (s_wr_miss |=> !csr_wr_denied)
        else $error("write to another register refused here");
    AST_WRITE_IDLE: assert property (!csr_wr_en |=> !csr_wr_denied)
        else $error("write refusal without a write");
endmodule : vector_type_config_register

// ==== vtype_defs.svh ====
`ifndef VTYPE_DEFS_SVH
`define VTYPE_DEFS_SVH

// Implementation constants of the hart.
`define VT_XLEN 32
`define VT_WIDEST_ELEMENT_BITS 64
`define VT_WIDEST_ELEMENT_BITS_LOG 6
`define VT_VECTOR_REGISTER_BITS_LOG 7
`define VT_NARROWEST_ELEMENT_BITS_LOG 3
`define VT_CNT_W 17

// Field layout of the type register.
`define VT_VILL_BIT 31
`define VT_RSV_HI 30
`define VT_RSV_LO 8
`define VT_VMA_BIT 7
`define VT_VTA_BIT 6
`define VT_SEW_HI 5
`define VT_SEW_LO 3
`define VT_REGISTER_GROUP_MULTIPLIER_HI 2
`define VT_REGISTER_GROUP_MULTIPLIER_LO 0
`define VT_REGISTER_GROUP_MULTIPLIER_RSV 3'h4

// Register address, reset value and derived-count helpers.
`define VT_CSR_ADDR 12'hc21
`define VT_RESET_VAL 32'h80000000
`define VT_ONE_CNT 17'h00001
`define VT_EIGHT 8'h08
`define VT_ELEMS_AT_8 17'h00010
`define VT_MAX_CNT 17'h00080
`define VT_WIDEST_BITS 16'h0040
`define VT_STATE_RESET 9'h100
`define VT_STATE7_RESET 7'h18

`endif

// ==== vtype_pkg.sv ====
package vtype_pkg;
    typedef logic [31:0] vtype_word_t;
    typedef logic signed [4:0] log2_t;

    typedef enum logic [2:0] {
        REGISTER_GROUP_MULTIPLIER_1 = 3'b000,
        REGISTER_GROUP_MULTIPLIER_2 = 3'b001,
        REGISTER_GROUP_MULTIPLIER_4 = 3'b010,
        REGISTER_GROUP_MULTIPLIER_8 = 3'b011,
        REGISTER_GROUP_MULTIPLIER_RSV = 3'b100,
        REGISTER_GROUP_MULTIPLIER_1_8 = 3'b101,
        REGISTER_GROUP_MULTIPLIER_1_4 = 3'b110,
        REGISTER_GROUP_MULTIPLIER_1_2 = 3'b111
    } register_group_multiplier_code_e;

    typedef enum logic [2:0] {
        SEW_8 = 3'b000,
        SEW_16 = 3'b001,
        SEW_32 = 3'b010,
        SEW_64 = 3'b011
    } sew_code_e;
endpackage : vtype_pkg

// ==== vtype_legality.sv ====
`timescale 1ns/1ns
`include "vtype_defs.svh"

module vtype_legality
    import vtype_pkg::*;
(
    input wire logic [31:0] req_vtype, // Requested type word
    output logic legal // Combination is supported
);
    log2_t register_group_multiplier_exp;
    log2_t sew_log;
    log2_t frac_cap;
    logic rsv_ok;
    logic sew_ok;
    logic register_group_multiplier_ok;

    always_comb begin
        // The multiplier code is a signed power-of-two exponent.
        register_group_multiplier_exp = log2_t'($signed(req_vtype[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO]));
        sew_log = log2_t'(req_vtype[`VT_SEW_LO+1:`VT_SEW_LO]) + log2_t'(`VT_NARROWEST_ELEMENT_BITS_LOG);
        frac_cap = (register_group_multiplier_exp < 0) ? log2_t'(`VT_WIDEST_ELEMENT_BITS_LOG) + register_group_multiplier_exp : log2_t'(`VT_WIDEST_ELEMENT_BITS_LOG);
        rsv_ok = (req_vtype[`VT_RSV_HI:`VT_RSV_LO] == '0);
        register_group_multiplier_ok = (req_vtype[`VT_REGISTER_GROUP_MULTIPLIER_HI:`VT_REGISTER_GROUP_MULTIPLIER_LO] != `VT_REGISTER_GROUP_MULTIPLIER_RSV)
            && (register_group_multiplier_exp >= log2_t'(`VT_NARROWEST_ELEMENT_BITS_LOG) - log2_t'(`VT_WIDEST_ELEMENT_BITS_LOG));
        // Widths from the narrowest up to the widest, or up to multiplier times widest for a fractional multiplier, are accepted.
        sew_ok = !req_vtype[`VT_SEW_HI] && (sew_log <= frac_cap);
        legal = rsv_ok && register_group_multiplier_ok && sew_ok;
    end
endmodule : vtype_legality

// ==== cfg_issuer.sv ====
`timescale 1ns/1ns

module cfg_issuer
    import vtype_pkg::*;
(
    input wire logic clk, // Core clock
    output logic cfg_valid, // Instruction retires
    output logic [31:0] cfg_vtype // Requested type word
);
    initial begin
        cfg_valid = 1'b0;
        cfg_vtype = 32'h0;
    end

    // Retires one configuration instruction; changes land just after the falling edge.
    task send(input logic [31:0] w);
        @(negedge clk);
        cfg_valid = 1'b1;
        cfg_vtype = w;
    endtask : send

    // Drops the strobe; the word is scrambled so a stale value is never reused.
    task idle();
        @(negedge clk);
        cfg_valid = 1'b0;
        cfg_vtype = ~cfg_vtype;
    endtask : idle
endmodule : cfg_issuer

// ==== vector_type_config_register_tb.sv ====
`timescale 1ns/1ns
`include "vtype_defs.svh"

module vector_type_config_register_tb
    import vtype_pkg::*;
;
    logic clk, rst, cfg_valid, csr_rd_en, csr_wr_en, csr_rd_valid, csr_wr_denied;
    logic illegal, tail_agnostic, mask_agnostic, wide_legal, cfg_done;
    logic [31:0] cfg_vtype, csr_rd_data, vtype_value, w;
    logic [11:0] csr_addr;
    logic [7:0] sew_bits;
    logic [2:0] register_group_multiplier_code, wide_register_group_multiplier_code;
    logic [16:0] elems_per_reg, max_element_count;
    int n_errors = 0, checked = 0, cycles = 0;

    vector_type_config_register dut (.clk(clk), .rst(rst), .cfg_valid(cfg_valid), .cfg_vtype(cfg_vtype),
        .csr_rd_en(csr_rd_en), .csr_wr_en(csr_wr_en), .csr_addr(csr_addr), .csr_rd_data(csr_rd_data),
        .csr_rd_valid(csr_rd_valid), .csr_wr_denied(csr_wr_denied), .vtype_value(vtype_value),
        .illegal(illegal), .tail_agnostic(tail_agnostic), .mask_agnostic(mask_agnostic),
        .sew_bits(sew_bits), .register_group_multiplier_code(register_group_multiplier_code), .elems_per_reg(elems_per_reg),
        .max_element_count(max_element_count), .wide_register_group_multiplier_code(wide_register_group_multiplier_code),
        .wide_legal(wide_legal), .cfg_done(cfg_done));
    cfg_issuer issuer (.clk(clk), .cfg_valid(cfg_valid), .cfg_vtype(cfg_vtype));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task results();
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end

    task cmp(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : cmp

    // Works out the decoded outputs for an accepted or refused request and compares, the double-width multiplier for an accepted one only.
    task exp_cfg(input logic [31:0] r);
        logic [2:0] s, l;
        logic ok;
        logic [16:0] e, m;
        s = r[5:3];
        l = r[2:0];
        ok = (r[30:8] == 0) && !s[2] && l != 3'h4 && (!l[2] || (8 << s) <= (64 >> (8 - l)));
        e = ok ? 17'(128 / (8 << s)) : 17'h0;
        m = !ok ? 17'h0 : (!l[2] ? e << l : e >> (8 - l));
        cmp(vtype_value, ok ? {24'h0, r[7:0]} : 32'h80000000);
        cmp(32'(illegal), 32'(!ok));
        cmp(32'({mask_agnostic, tail_agnostic}), ok ? 32'(r[7:6]) : 32'h0);
        cmp(32'(sew_bits), ok ? 32'(8 << s) : 32'h0);
        cmp(32'(register_group_multiplier_code), ok ? 32'(l) : 32'h0);
        cmp(32'(elems_per_reg), 32'(e));
        cmp(32'(max_element_count), 32'(m));
        cmp(32'(wide_legal), 32'(ok && l != 3'h3 && s < 3'h3));
        if (ok) begin
            cmp(32'(wide_register_group_multiplier_code), 32'(3'(l + 3'h1)));
        end
        cmp(32'(cfg_done), 32'h1);
    endtask : exp_cfg

    task csr(input logic wr, input logic [11:0] a, input logic exp_ok, input logic [31:0] exp_data);
        @(negedge clk);
        csr_wr_en = wr;
        csr_rd_en = !wr;
        csr_addr = a;
        @(negedge clk);
        csr_wr_en = 1'b0;
        csr_rd_en = 1'b0;
        csr_addr = ~a;
        cmp(32'(wr ? csr_wr_denied : csr_rd_valid), 32'(exp_ok));
        cmp(csr_rd_data, exp_data);
    endtask : csr

    initial begin
        rst = 1'b1;
        csr_rd_en = 1'b0;
        csr_wr_en = 1'b0;
        csr_addr = 12'h0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmp(vtype_value, `VT_RESET_VAL);
        csr(1'b0, `VT_CSR_ADDR, 1'b1, `VT_RESET_VAL);
        // Every width and multiplier code, sent back to back.
        for (int i = 0; i < 64; i++) begin
            issuer.send({24'h0, i[1], i[0], i[5:0]});
            if (i > 0) begin
                exp_cfg(w);
            end
            w = {24'h0, i[1], i[0], i[5:0]};
        end
        issuer.idle();
        exp_cfg(w);
        issuer.send(32'h000000d1);
        issuer.idle();
        exp_cfg(32'h000000d1);
        csr(1'b1, `VT_CSR_ADDR, 1'b1, 32'h0);
        cmp(vtype_value, 32'h000000d1);
        csr(1'b0, 12'hc20, 1'b0, 32'h0);
        csr(1'b1, 12'hc20, 1'b0, 32'h0);
        csr(1'b0, `VT_CSR_ADDR, 1'b1, 32'h000000d1);
        issuer.send(32'h000001d1);
        issuer.idle();
        exp_cfg(32'h000001d1);
        csr(1'b0, `VT_CSR_ADDR, 1'b1, `VT_RESET_VAL);
        results();
    end
endmodule : vector_type_config_register_tb
